// [hw/cdh_pkg.sv]
package cdh_pkg;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int CDH_CLK_MHZ        = 100;
	localparam int CDH_MAX_MEM_CYCLES = 3;
	localparam int CDH_HOLD_LAT_CLKS  = 7;
	localparam int CDH_MEM_CLKS       = 2;
	localparam int CDH_WIN_CLKS       = 2;

	localparam logic [1:0] CDH_MEM_LAST = 2'(CDH_MEM_CLKS - 1);
	localparam logic [1:0] CDH_WIN_LAST = 2'(CDH_WIN_CLKS - 1);
	localparam logic [1:0] CDH_CNT_ZERO = 2'h0;

	// ------------------------------------------------------------
	// Bus widths and idle values
	// ------------------------------------------------------------
	localparam int CDH_AW = 15;
	localparam int CDH_DW = 16;
	localparam logic [CDH_AW-1:0] CDH_ADDR_IDLE = 15'h7FFF;
	localparam logic [CDH_DW-1:0] CDH_DATA_IDLE = 16'hFFFF;

	typedef enum logic [1:0] {
		CDH_MODE_HOLD,
		CDH_MODE_CLKSTOP,
		CDH_MODE_TRANSP
	} cdh_mode_t;

	typedef enum {
		CDH_ST_ALU,
		CDH_ST_MEM,
		CDH_ST_HOLD
	} cdh_state_t;

endpackage

// [hw/cdh_win_timer.sv]
`timescale 1ns/1ps
`default_nettype none

module cdh_win_timer
	import cdh_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       reset,
	input  wire logic       start,
	output var  logic       active
);

	logic [1:0] cnt_r;

	// ------------------------------------------------------------
	// Two-clock window after a memory cycle ends
	// ------------------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (reset)
			cnt_r <= CDH_CNT_ZERO;
		else if (start)
			cnt_r <= CDH_WIN_LAST + 2'h1;
		else if (cnt_r != CDH_CNT_ZERO)
			cnt_r <= cnt_r - 2'h1;
	end

	assign active = (cnt_r != CDH_CNT_ZERO);

endmodule

`default_nettype wire

// [hw/cdh_bus_handover.sv]
//
// Summary of operation
// - A pending hold is taken at the start of the next non-memory cycle, raising the acknowledge.
// - Hold latency is at most one clock plus one memory cycle, three clocks without waits.
// - While acknowledged, address, data, direction, cycle-done, write and memory enable float high.
// - The controller releases hold when done and the processor then resumes bus operation.
// - Apart from the window timer, the processor keeps its state however long its clock is stopped.
// - Every end of memory enable is followed by at least one cycle with no memory access.
//
`timescale 1ns/1ps
`default_nettype none

module cdh_bus_handover
	import cdh_pkg::*;
(
	input  wire logic              clk,
	input  wire logic              reset,
	input  wire logic              cpu_clk_run,
	input  wire logic              hold_req_n,
	input  wire logic              mem_req,
	input  wire logic              mem_write,
	input  wire logic [CDH_AW-1:0] mem_addr,
	input  wire logic [CDH_DW-1:0] mem_wdata,
	input  wire logic              mem_ready,
	output logic                   mem_busy,
	output logic [CDH_AW-1:0]      addr_o,
	output logic                   addr_oe,
	output logic [CDH_DW-1:0]      data_o,
	output logic                   data_oe,
	output logic                   read_direction,
	output logic                   machine_cycle_done,
	output logic                   write_strobe_n,
	output logic                   memory_cycle_enable_n,
	output logic                   bus_grant_ack,
	output logic                   transparent_window
);

	cdh_state_t        state_r;
	logic [1:0]        mcnt_r;
	logic [CDH_AW-1:0] addr_r;
	logic [CDH_DW-1:0] data_r;
	logic              wr_r;
	logic              done_r;
	logic              mem_end;
	logic              hold_pend;

	// ------------------------------------------------------------
	// Hold request and memory cycle end
	// ------------------------------------------------------------
	// Processor clock gating models the static core: all state except the window timer in cdh_win_timer simply waits
	assign hold_pend = !hold_req_n;
	assign mem_end   = (state_r == CDH_ST_MEM) && (mcnt_r == CDH_MEM_LAST)
			   && mem_ready && cpu_clk_run;

	// ------------------------------------------------------------
	// Machine cycle sequencer
	// ------------------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (reset)
			state_r <= CDH_ST_ALU;
		else if (cpu_clk_run)
		begin
			case (state_r)
				CDH_ST_ALU:
				begin
					// Hold wins only at an ALU cycle boundary
					if (hold_pend)
						state_r <= CDH_ST_HOLD;
					else if (mem_req)
						state_r <= CDH_ST_MEM;
				end
				CDH_ST_MEM:
				begin
					if (mem_end)
						state_r <= CDH_ST_ALU;
				end
				CDH_ST_HOLD:
				begin
					if (!hold_pend)
						state_r <= CDH_ST_ALU;
				end
				default:
					state_r <= CDH_ST_ALU;
			endcase
		end
	end

	always_ff @(posedge clk)
	begin
		if (reset)
			mcnt_r <= CDH_CNT_ZERO;
		else if (!cpu_clk_run)
			mcnt_r <= mcnt_r;
		else if (state_r == CDH_ST_MEM && mcnt_r != CDH_MEM_LAST)
			mcnt_r <= mcnt_r + 2'h1;
		else if (state_r != CDH_ST_MEM || mem_end)
			mcnt_r <= CDH_CNT_ZERO;
	end

	// ------------------------------------------------------------
	// Captured memory request
	// ------------------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			addr_r <= CDH_ADDR_IDLE;
			data_r <= CDH_DATA_IDLE;
			wr_r   <= 1'b0;
		end
		else if (cpu_clk_run && state_r == CDH_ST_ALU && !hold_pend
			 && mem_req)
		begin
			addr_r <= mem_addr;
			data_r <= mem_wdata;
			wr_r   <= mem_write;
		end
	end

	// ------------------------------------------------------------
	// Cycle end marker, frozen with the processor clock
	// ------------------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (reset)
			done_r <= 1'b0;
		else if (cpu_clk_run)
			done_r <= mem_end;
	end

	// ------------------------------------------------------------
	// Address pins; released lines float high via pull-ups
	// ------------------------------------------------------------
	always_comb
	begin
		addr_o  = CDH_ADDR_IDLE;
		addr_oe = 1'b0;
		if (state_r == CDH_ST_MEM)
		begin
			addr_o  = addr_r;
			addr_oe = 1'b1;
		end
		if (state_r == CDH_ST_HOLD)
			addr_oe = 1'b0;
	end

	// ------------------------------------------------------------
	// Data pins; only a write cycle turns the drivers on
	// ------------------------------------------------------------
	always_comb
	begin
		data_o         = CDH_DATA_IDLE;
		data_oe        = 1'b0;
		read_direction = 1'b1;
		if (state_r == CDH_ST_MEM)
		begin
			data_o         = data_r;
			data_oe        = wr_r;
			read_direction = !wr_r;
		end
		if (state_r == CDH_ST_HOLD)
		begin
			data_oe        = 1'b0;
			read_direction = 1'b1;
		end
	end

	// ------------------------------------------------------------
	// Memory strobes
	// ------------------------------------------------------------
	always_comb
	begin
		write_strobe_n        = 1'b1;
		memory_cycle_enable_n = 1'b1;
		if (state_r == CDH_ST_MEM)
		begin
			memory_cycle_enable_n = 1'b0;
			// Strobe in the last clock so address and data settle first
			write_strobe_n        = !(wr_r && mcnt_r == CDH_MEM_LAST);
		end
		if (state_r == CDH_ST_HOLD)
		begin
			write_strobe_n        = 1'b1;
			memory_cycle_enable_n = 1'b1;
		end
	end

	// ------------------------------------------------------------
	// Cycle done pin and hold acknowledge
	// ------------------------------------------------------------
	always_comb
	begin
		machine_cycle_done = 1'b1;
		if (state_r != CDH_ST_HOLD)
			machine_cycle_done = !done_r;
	end

	assign bus_grant_ack = (state_r == CDH_ST_HOLD);
	assign mem_busy      = (state_r == CDH_ST_MEM);

	// ------------------------------------------------------------
	// Transparent window after memory enable rises
	// ------------------------------------------------------------
	cdh_win_timer u_win (
		.clk    (clk),
		.reset  (reset),
		.start  (mem_end),
		.active (transparent_window)
	);

endmodule

`default_nettype wire

// [verification/cdh_handover_props.sv]
`timescale 1ns/1ps
`default_nettype none
module cdh_handover_props(
	input wire logic clk,
	input wire logic reset,
	input wire logic cpu_clk_run,
	input wire logic hold_req_n,
	input wire logic bus_grant_ack,
	input wire logic addr_oe,
	input wire logic data_oe,
	input wire logic write_strobe_n,
	input wire logic memory_cycle_enable_n,
	input wire logic machine_cycle_done,
	input wire logic transparent_window
);
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	a_ack_float: assert property (bus_grant_ack |->
		!addr_oe && !data_oe && write_strobe_n && memory_cycle_enable_n)
		else $error("bus kept in hold");
	a_ack_cause: assert property ($rose(bus_grant_ack) |->
		!$past(hold_req_n)) else $error("ack without hold");
	a_hold_lat: assert property ($fell(hold_req_n) && cpu_clk_run |->
		##[1:7] bus_grant_ack) else $error("hold too slow");
	a_hold_end: assert property (hold_req_n && bus_grant_ack &&
		cpu_clk_run |=> !bus_grant_ack) else $error("ack stuck");
	a_mem_gap: assert property (!machine_cycle_done |->
		memory_cycle_enable_n) else $error("no idle cycle");
	a_win_cause: assert property ($rose(transparent_window) |->
		!$past(memory_cycle_enable_n)) else $error("window without cycle");
	a_win_len: assert property ($rose(transparent_window) |->
		##1 transparent_window ##1 !transparent_window)
		else $error("window length");
	a_frozen: assert property (!cpu_clk_run |=>
		$stable(bus_grant_ack) && $stable(memory_cycle_enable_n))
		else $error("moved while stopped");
endmodule
`default_nettype wire

// [verification/cdh_dma_model.sv]
`timescale 1ns/1ps
`default_nettype none
module cdh_dma_model(
	input  wire logic       clk,
	input  wire logic       reset,
	input  wire logic       go,
	input  wire logic       stop_go,
	input  wire logic       tp_en,
	input  wire logic       ack,
	input  wire logic       mem_busy,
	input  wire logic       mem_req,
	input  wire logic       window,
	output var  logic       hold_req_n,
	output var  logic       cpu_clk_run,
	output var  logic       dma_grant,
	output var  logic       buf_off,
	output var  logic       done,
	output var  logic [3:0] tp_count
);
	logic [3:0] cnt_r;
	logic [3:0] scnt_r;
	logic       spend_r;
	logic       win_d_r;
	// Hold/acknowledge block transfers
	always_ff @(posedge clk)
	begin
		done <= 1'b0;
		if (reset)
		begin
			hold_req_n <= 1'b1;
			cnt_r      <= 4'h0;
		end
		else if (go)
		begin
			hold_req_n <= 1'b0;
			cnt_r      <= 4'h3;
		end
		else if (!hold_req_n && ack)
		begin
			cnt_r      <= cnt_r - 4'h1;
			hold_req_n <= cnt_r == 4'h0;
			done       <= cnt_r == 4'h0;
		end
	end
	// Clock-stopped transfers; halts only between machine cycles
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			cpu_clk_run <= 1'b1;
			dma_grant   <= 1'b0;
			spend_r     <= 1'b0;
			scnt_r      <= 4'h0;
		end
		else if (dma_grant)
		begin
			scnt_r <= scnt_r - 4'h1;
			if (scnt_r == 4'h1)
			begin
				dma_grant   <= 1'b0;
				cpu_clk_run <= 1'b1;
			end
		end
		else if ((stop_go || spend_r) && !mem_busy && !mem_req)
		begin
			spend_r     <= 1'b0;
			cpu_clk_run <= 1'b0;
			dma_grant   <= 1'b1;
			scnt_r      <= 4'h4;
		end
		else if (stop_go)
			spend_r <= 1'b1;
	end
	// Transparent transfers: one per window, buffers off meanwhile
	assign buf_off = dma_grant || (tp_en && window);
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			win_d_r  <= 1'b0;
			tp_count <= 4'h0;
		end
		else
		begin
			win_d_r <= window;
			if (tp_en && window && !win_d_r)
				tp_count <= tp_count + 4'h1;
		end
	end
endmodule
`default_nettype wire

// [verification/testbench.sv]
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import cdh_pkg::*;
	logic clk = 1'b0, reset = 1'b1, cpu_clk_run, mem_req = 1'b0;
	logic stop_go = 1'b0, tp_en = 1'b0, dma_grant, buf_off;
	logic [3:0] tp_count;
	logic mem_write = 1'b0, mem_ready = 1'b1, go = 1'b0, done, mem_busy;
	logic hold_req_n, addr_oe, data_oe, read_direction, machine_cycle_done;
	logic write_strobe_n, memory_cycle_enable_n, bus_grant_ack;
	logic transparent_window;
	logic [CDH_AW-1:0] mem_addr = 15'h0000, addr_o;
	logic [CDH_DW-1:0] mem_wdata = 16'h0000, data_o;
	int err_count = 0, check_count = 0, n;
	always #5 clk = ~clk;
	cdh_bus_handover DUT(.clk, .reset, .cpu_clk_run, .hold_req_n, .mem_req,
		.mem_write, .mem_addr, .mem_wdata, .mem_ready, .mem_busy, .addr_o,
		.addr_oe, .data_o, .data_oe, .read_direction, .machine_cycle_done,
		.write_strobe_n, .memory_cycle_enable_n, .bus_grant_ack,
		.transparent_window);
	cdh_dma_model dma(.clk, .reset, .go, .stop_go, .tp_en,
		.ack(bus_grant_ack), .mem_busy, .mem_req,
		.window(transparent_window), .hold_req_n, .cpu_clk_run,
		.dma_grant, .buf_off, .done, .tp_count);
	task tk(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask
	task chk(input logic [15:0] g, e);
		check_count++;
		if (g !== e)
		begin
			err_count++;
			$display("ERROR %0t got %h exp %h", $time, g, e);
		end
	endtask
	task conclude;
		$display("errors %0d checks %0d", err_count, check_count);
		if (err_count == 0 && check_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task t_mem(input logic w, input logic [15:0] v);
		mem_req = 1'b1;
		mem_write = w;
		mem_addr = v[14:0];
		mem_wdata = v;
		for (n = 0; n < 9 && memory_cycle_enable_n !== 1'b0; n++)
			tk(1);
		mem_req = 1'b0;
		chk({addr_oe, addr_o}, {1'b1, v[14:0]});
		chk({14'h0, read_direction, data_oe}, {14'h0, !w, w});
		chk({14'h0, mem_busy, memory_cycle_enable_n}, 16'h2);
		if (w)
			chk(data_o, v);
		tk(1);
		chk({15'h0, write_strobe_n}, {15'h0, !w});
		tk(1);
		chk({13'h0, transparent_window, machine_cycle_done,
			memory_cycle_enable_n}, 16'h5);
		chk({15'h0, buf_off}, {15'h0, tp_en});
		tk(2);
	endtask
	task t_window;
		logic [3:0] c0;
		c0 = tp_count;
		tp_en = 1'b1;
		t_mem(1'b1, 16'h3C5A);
		tp_en = 1'b0;
		chk({12'h0, tp_count}, {12'h0, c0 + 4'h1});
	endtask
	task t_hold;
		mem_req = 1'b1;
		for (n = 0; n < 9 && memory_cycle_enable_n !== 1'b0; n++)
			tk(1);
		go = 1'b1;
		tk(1);
		go = 1'b0;
		for (n = 0; n < 12 && bus_grant_ack !== 1'b1; n++)
			tk(1);
		chk({15'h0, n <= 7}, 16'h1);
		chk({12'h0, addr_oe, data_oe, write_strobe_n,
			memory_cycle_enable_n}, 16'h3);
		for (n = 0; n < 20 && done !== 1'b1; n++)
			tk(1);
		tk(1);
		chk({15'h0, bus_grant_ack}, 16'h0);
		for (n = 0; n < 4 && memory_cycle_enable_n !== 1'b0; n++)
			tk(1);
		chk({15'h0, memory_cycle_enable_n}, 16'h0);
		mem_req = 1'b0;
		tk(4);
	endtask
	task t_freeze;
		stop_go = 1'b1;
		go = 1'b1;
		tk(1);
		stop_go = 1'b0;
		go = 1'b0;
		chk({13'h0, dma_grant, cpu_clk_run, buf_off}, 16'h5);
		tk(3);
		chk({15'h0, bus_grant_ack}, 16'h0);
		for (n = 0; n < 8 && cpu_clk_run !== 1'b1; n++)
			tk(1);
		chk({14'h0, dma_grant, cpu_clk_run}, 16'h1);
		for (n = 0; n < 8 && bus_grant_ack !== 1'b1; n++)
			tk(1);
		chk({15'h0, bus_grant_ack}, 16'h1);
		tk(12);
	endtask
	initial
	begin
		tk(3);
		reset = 1'b0;
		t_mem(1'b0, 16'h2AD5);
		t_mem(1'b1, 16'hD52A);
		t_window;
		t_hold;
		t_freeze;
		conclude;
	end
	initial
	begin
		#20000;
		err_count++;
		conclude;
	end
endmodule
bind cdh_bus_handover cdh_handover_props u_chk(.clk, .reset, .cpu_clk_run,
	.hold_req_n, .bus_grant_ack, .addr_oe, .data_oe, .write_strobe_n,
	.memory_cycle_enable_n, .machine_cycle_done, .transparent_window);
`default_nettype wire
